// ### logic/sysref_delay_calibration_config.sv
// Summary of operation
// - delay step is (1+multiplier)/(8*oscillator frequency)
// - codes give 131/262/393/524ps; resets to zero
// - nine-bit feedback divider, read-write, resets eight
// - seven-bit input divider, read-write, resets eight
// - writing trigger one runs calibration, bit self-clears
// - fifteen-bit read-only calibration result field
`timescale 1ns/1ns
`default_nettype none
module sysref_delay_calibration_config
  import delay_cal_pkg::*;
#(
  parameter int SETTLE = CAL_SETTLE_CYCLES
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              spi_cs_b_i,
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_sdio_i,
  output logic                   spi_sdio_o,
  output logic                   spi_sdio_oe_o,
  input  wire logic              cal_cmp_high_i,
  output cal_cfg_t               cfg_o,
  output logic [2:0]             step_units_o,
  output logic [RES_W-1:0]       cal_trial_o,
  output logic                   cal_busy_o
);

  pins_t              s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
  logic               sclk_prev_reg;
  logic [4:0]         bit_cnt_reg, bit_cnt_next;
  logic [15:0]        shift_reg, shift_next;
  logic [7:0]         out_reg, out_next;
  logic               rd_reg, rd_next;
  logic               sdio_reg, sdio_next;
  logic               oe_reg, oe_next;
  logic               wr_stb;
  logic [ADDR_W-1:0]  wr_addr;
  logic [DATA_W-1:0]  wr_data;
  logic               rise, fall;

  cal_cfg_t           cfg_reg, cfg_next;
  logic [2:0]         units_reg, units_next;
  logic               start_reg, start_next;
  logic               busy_reg;
  logic [RES_W-1:0]   trial;
  logic [RES_W-1:0]   result;
  logic               eng_busy;
  logic               eng_done;

  // read data of one register
  function automatic logic [DATA_W-1:0] read_data(
    input logic [ADDR_W-1:0] addr,
    input cal_cfg_t          cfg,
    input logic [RES_W-1:0]  res,
    input logic              busy);
    read_data = 8'h00;
    case (addr)
      ADDR_CTRL: begin
        read_data[MULT_LSB +: MULT_W] = cfg.mult;
        read_data[FB_MSB_POS] = cfg.fb_div[8];
      end
      ADDR_FB_LO:  read_data = cfg.fb_div[7:0];
      ADDR_IN_DIV: read_data = {1'b0, cfg.in_div};
      ADDR_RES_HI: read_data = {1'b0, res[14:8]};
      ADDR_RES_LO: read_data = res[7:0];
      ADDR_CAL:    read_data[CAL_TRIG_POS] = busy;
      default:     read_data = 8'h00;
    endcase
  endfunction : read_data

  // ----------------------------------------------------------------------
  // pin synchronisers: three stages, accept when stages two and three agree
  // ----------------------------------------------------------------------
  always_comb begin
    pin_next = pin_reg;
    if (s2_reg.cs_b == s3_reg.cs_b) begin
      pin_next.cs_b = s3_reg.cs_b;
    end
    if (s2_reg.sclk == s3_reg.sclk) begin
      pin_next.sclk = s3_reg.sclk;
    end
    if (s2_reg.sdio == s3_reg.sdio) begin
      pin_next.sdio = s3_reg.sdio;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s1_reg <= PINS_IDLE;
      s2_reg <= PINS_IDLE;
      s3_reg <= PINS_IDLE;
      pin_reg <= PINS_IDLE;
      sclk_prev_reg <= 1'b0;
    end else begin
      s1_reg <= {spi_cs_b_i, spi_sclk_i, spi_sdio_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
      sclk_prev_reg <= pin_reg.sclk;
    end
  end

  assign rise = pin_reg.sclk & ~sclk_prev_reg;
  assign fall = ~pin_reg.sclk & sclk_prev_reg;

  // ----------------------------------------------------------------------
  // serial frame: r/w bit, 7-bit address, 8 data bits, msb first
  // ----------------------------------------------------------------------
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    out_next = out_reg;
    rd_next = rd_reg;
    sdio_next = sdio_reg;
    oe_next = oe_reg;
    wr_stb = 1'b0;
    wr_addr = shift_reg[13:7];
    wr_data = {shift_reg[6:0], pin_reg.sdio};
    if (pin_reg.cs_b) begin
      bit_cnt_next = 5'h00;
      rd_next = 1'b0;
      oe_next = 1'b0;
    end else if (rise && bit_cnt_reg < FRAME_BITS) begin
      shift_next = {shift_reg[14:0], pin_reg.sdio};
      bit_cnt_next = bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == CMD_BITS - 5'h01 && shift_reg[6]) begin
        rd_next = 1'b1;
        out_next = read_data({shift_reg[5:0], pin_reg.sdio}, cfg_reg,
                             result, busy_reg);
      end
      if (bit_cnt_reg == FRAME_BITS - 5'h01 && !shift_reg[14]) begin
        wr_stb = 1'b1;
      end
    end else if (fall && rd_reg && bit_cnt_reg < FRAME_BITS) begin
      sdio_next = out_reg[7];
      out_next = {out_reg[6:0], 1'b0};
      oe_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      out_reg <= 8'h00;
      rd_reg <= 1'b0;
      sdio_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      out_reg <= out_next;
      rd_reg <= rd_next;
      sdio_reg <= sdio_next;
      oe_reg <= oe_next;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers and calibration trigger
  // ----------------------------------------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    start_next = 1'b0;
    if (wr_stb) begin
      case (wr_addr)
        ADDR_CTRL: begin
          cfg_next.mult = wr_data[MULT_LSB +: MULT_W];
          cfg_next.fb_div[8] = wr_data[FB_MSB_POS];
        end
        ADDR_FB_LO:  cfg_next.fb_div[7:0] = wr_data;
        ADDR_IN_DIV: cfg_next.in_div = wr_data[6:0];
        ADDR_CAL:    start_next = wr_data[CAL_TRIG_POS] & ~busy_reg;
        default:     cfg_next = cfg_reg;
      endcase
    end
    units_next = {1'b0, cfg_next.mult} + 3'h1;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cfg_reg <= {MULT_RESET, FBDIV_RESET, INDIV_RESET};
      units_reg <= 3'h1;
      start_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      units_reg <= units_next;
      start_reg <= start_next;
    end
  end

  // busy reads back as the self-clearing trigger bit
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= start_reg | eng_busy;
    end
  end

  delay_cal_engine #(
    .SETTLE     (SETTLE)
  ) u_engine (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .start_i    (start_reg),
    .cmp_high_i (cal_cmp_high_i),
    .busy_o     (eng_busy),
    .done_o     (eng_done),
    .trial_o    (trial),
    .result_o   (result)
  );

  assign spi_sdio_o = sdio_reg;
  assign spi_sdio_oe_o = oe_reg;
  assign cfg_o = cfg_reg;
  assign step_units_o = units_reg;
  assign cal_trial_o = trial;
  assign cal_busy_o = busy_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_step_units: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    step_units_o == {1'b0, cfg_o.mult} + 3'h1)
    else $error("delay step units do not follow the multiplier");

  a_reset_vals: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> cfg_o.mult == 2'h0 && cfg_o.fb_div == 9'h008
                       && cfg_o.in_div == 7'h08)
    else $error("configuration reset values wrong");

  a_write_fb: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    wr_stb && wr_addr == ADDR_FB_LO |=> cfg_o.fb_div[7:0] == $past(wr_data))
    else $error("feedback divider write lost");

  a_write_in: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    wr_stb && wr_addr == ADDR_IN_DIV |=> cfg_o.in_div == $past(wr_data[6:0]))
    else $error("input divider write lost");

  a_trig_start: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    wr_stb && wr_addr == ADDR_CAL && wr_data[7] && !busy_reg
      |=> ##1 cal_busy_o ##1 eng_busy)
    else $error("calibration trigger did not start the engine");

  a_trig_clears: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    eng_done |=> !cal_busy_o)
    else $error("trigger bit did not clear after calibration");

  c_write_cfg: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_stb && wr_addr == ADDR_CTRL);
  c_read_res: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    rd_reg && oe_reg);

endmodule : sysref_delay_calibration_config
`default_nettype wire

// ### pkg/delay_cal_pkg.sv
`default_nettype none
package delay_cal_pkg;

  // ----------------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------------
  localparam int MULT_W = 2;
  localparam int FBDIV_W = 9;
  localparam int INDIV_W = 7;
  localparam int RES_W = 15;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------------
  // register byte addresses on the serial port
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 7'h19;
  localparam logic [ADDR_W-1:0] ADDR_FB_LO = 7'h1a;
  localparam logic [ADDR_W-1:0] ADDR_IN_DIV = 7'h1b;
  localparam logic [ADDR_W-1:0] ADDR_RES_HI = 7'h6c;
  localparam logic [ADDR_W-1:0] ADDR_RES_LO = 7'h6d;
  localparam logic [ADDR_W-1:0] ADDR_CAL = 7'h72;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int MULT_LSB = 5;
  localparam int FB_MSB_POS = 0;
  localparam int CAL_TRIG_POS = 7;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [MULT_W-1:0] MULT_RESET = 2'h0;
  localparam logic [FBDIV_W-1:0] FBDIV_RESET = 9'h008;
  localparam logic [INDIV_W-1:0] INDIV_RESET = 7'h08;
  localparam logic [RES_W-1:0] RES_RESET = 15'h0000;

  // ----------------------------------------------------------------------
  // serial frame and timing
  // ----------------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAL_SETTLE_NS = 1000;
  localparam int CAL_SETTLE_CYCLES =
    (CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cs_b;
    logic sclk;
    logic sdio;
  } pins_t;

  localparam pins_t PINS_IDLE = 3'h4;

  typedef struct packed {
    logic [MULT_W-1:0]  mult;
    logic [FBDIV_W-1:0] fb_div;
    logic [INDIV_W-1:0] in_div;
  } cal_cfg_t;

  // one-hot mask for a result bit position
  function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] idx);
    bit_mask = 15'h0001 << idx;
  endfunction : bit_mask

endpackage : delay_cal_pkg
`default_nettype wire

// ### logic/delay_cal_engine.sv
`timescale 1ns/1ns
`default_nettype none
module delay_cal_engine
  import delay_cal_pkg::*;
#(
  parameter int SETTLE = CAL_SETTLE_CYCLES
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             start_i,
  input  wire logic             cmp_high_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic [RES_W-1:0]      trial_o,
  output logic [RES_W-1:0]      result_o
);

  typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_DECIDE} cal_state_t;

  localparam int BUSY_BOUND = 400;

  cal_state_t        state_reg, state_next;
  logic [3:0]        idx_reg, idx_next;
  logic [7:0]        cnt_reg, cnt_next;
  logic [RES_W-1:0]  trial_reg, trial_next;
  logic [RES_W-1:0]  result_reg, result_next;
  logic              done_reg, done_next;
  logic [RES_W-1:0]  kept;

  // ----------------------------------------------------------------------
  // successive approximation of the calibration code
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    trial_next = trial_reg;
    result_next = result_reg;
    done_next = 1'b0;
    kept = cmp_high_i ? (trial_reg & ~bit_mask(idx_reg)) : trial_reg;
    case (state_reg)
      CAL_IDLE: begin
        if (start_i) begin
          idx_next = 4'he;
          cnt_next = 8'h00;
          trial_next = bit_mask(4'he);
          state_next = CAL_SETTLE;
        end
      end
      CAL_SETTLE: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(SETTLE - 1)) begin
          state_next = CAL_DECIDE;
        end
      end
      CAL_DECIDE: begin
        cnt_next = 8'h00;
        if (idx_reg == 4'h0) begin
          trial_next = kept;
          result_next = kept;
          done_next = 1'b1;
          state_next = CAL_IDLE;
        end else begin
          idx_next = idx_reg - 4'h1;
          trial_next = kept | bit_mask(idx_reg - 4'h1);
          state_next = CAL_SETTLE;
        end
      end
      default: begin
        state_next = CAL_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_reg <= CAL_IDLE;
      idx_reg <= 4'h0;
      cnt_reg <= 8'h00;
      trial_reg <= RES_RESET;
      result_reg <= RES_RESET;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      trial_reg <= trial_next;
      result_reg <= result_next;
      done_reg <= done_next;
    end
  end

  assign busy_o = (state_reg != CAL_IDLE);
  assign done_o = done_reg;
  assign trial_o = trial_reg;
  assign result_o = result_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_busy_ends: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(busy_o) |-> ##[1:BUSY_BOUND] !busy_o)
    else $error("calibration did not finish in time");

  a_result_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    !busy_o && $past(!busy_o) && !done_reg |-> $stable(result_o))
    else $error("result changed outside a calibration");

  c_cal_done: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    done_reg);

endmodule : delay_cal_engine
`default_nettype wire

// ### test/sysref_delay_calibration_config_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sysref_delay_calibration_config_tb_top
  import delay_cal_pkg::*;
;
  // ----------------------------------------------------------------------
  // bench settings and signals
  // ----------------------------------------------------------------------
  localparam int HALF    = 8;      // sclk half period in mclk cycles
  localparam int TIMEOUT = 20000;  // ceiling on the whole run

  logic                mclk_i;
  logic                rst_b_i;
  logic                spi_cs_b_i;
  logic                spi_sclk_i;
  logic                spi_sdio_i;
  logic                spi_sdio_o;
  logic                spi_sdio_oe_o;
  logic                host_sdio;
  logic                cal_cmp_high_i;
  cal_cfg_t            cfg_o;
  logic [2:0]          step_units_o;
  logic [RES_W-1:0]    cal_trial_o;
  logic                cal_busy_o;
  logic [RES_W-1:0]    target;
  logic [7:0]          rdata;
  logic [1:0]          m;
  logic [RES_W-1:0]    targets [3];
  int                  n_errors = 0;
  int                  n_compared = 0;
  int                  cycles = 0;
  int                  n;

  // three-wire data line: device wins while it drives
  assign spi_sdio_i = spi_sdio_oe_o ? spi_sdio_o : host_sdio;
  // comparator: trial code above the analog target reads as too high
  assign cal_cmp_high_i = (cal_trial_o > target);

  sysref_delay_calibration_config #(
    .SETTLE(CAL_SETTLE_CYCLES)
  ) sysref_delay_calibration_config_i (
    .mclk_i         (mclk_i),
    .rst_b_i        (rst_b_i),
    .spi_cs_b_i     (spi_cs_b_i),
    .spi_sclk_i     (spi_sclk_i),
    .spi_sdio_i     (spi_sdio_i),
    .spi_sdio_o     (spi_sdio_o),
    .spi_sdio_oe_o  (spi_sdio_oe_o),
    .cal_cmp_high_i (cal_cmp_high_i),
    .cfg_o          (cfg_o),
    .step_units_o   (step_units_o),
    .cal_trial_o    (cal_trial_o),
    .cal_busy_o     (cal_busy_o)
  );

  // ----------------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------------
  // free-running 20 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
  end

  // cut a hung run short and report it as a mismatch
  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == TIMEOUT) begin
      n_errors = n_errors + 1;
      $display("timeout after %0d cycles", cycles);
      results();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  // wait n edges, then step just past the edge
  task automatic tick(input int cnt);
    repeat (cnt) @(posedge mclk_i);
    #1;
  endtask : tick

  task automatic check(input string name, input logic [17:0] exp,
                       input logic [17:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one 16-bit frame: r/w flag, 7-bit address, 8 data bits, msb first
  task automatic xfer(input logic is_rd, input logic [6:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rd_o);
    logic [15:0] word;
    word = {is_rd, addr, wdata};
    rd_o = 8'h00;
    spi_cs_b_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      spi_sclk_i = 1'b0;
      host_sdio = (is_rd && i >= 8) ? 1'b0 : word[15-i];
      tick(HALF);
      if (is_rd && i >= 8) rd_o[15-i] = spi_sdio_i;
      spi_sclk_i = 1'b1;
      tick(HALF);
    end
    spi_sclk_i = 1'b0;
    tick(HALF);
    check("spi_sdio_oe_o", {17'h0, is_rd}, spi_sdio_oe_o);
    spi_cs_b_i = 1'b1;
    host_sdio = 1'b0;
    tick(HALF);
    check("spi_sdio_oe_o", 18'h0, spi_sdio_oe_o);
  endtask : xfer

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] dummy;
    xfer(1'b0, addr, data, dummy);
  endtask : wr

  task automatic rd(input logic [6:0] addr, output logic [7:0] data);
    xfer(1'b1, addr, 8'h00, data);
  endtask : rd

  // write frame cut after 15 bits: must commit nothing
  task automatic cut_wr(input logic [6:0] addr, input logic [7:0] data);
    logic [15:0] word;
    word = {1'b0, addr, data};
    spi_cs_b_i = 1'b0;
    for (int i = 0; i < 15; i++) begin
      spi_sclk_i = 1'b0;
      host_sdio = word[15-i];
      tick(HALF);
      spi_sclk_i = 1'b1;
      tick(HALF);
    end
    spi_sclk_i = 1'b0;
    tick(HALF);
    spi_cs_b_i = 1'b1;
    host_sdio = 1'b0;
    tick(HALF);
  endtask : cut_wr

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  // reset, then register and calibration scenarios
  initial begin
    rst_b_i = 1'b0;
    spi_cs_b_i = 1'b1;
    spi_sclk_i = 1'b0;
    host_sdio = 1'b0;
    target = 15'h5a5a;
    targets[0] = 15'h5a5a;
    targets[1] = 15'h7fff;
    targets[2] = 15'h0001;
    tick(10);
    rst_b_i = 1'b1;
    tick(6);

    // reset values of the configuration fields
    check("cfg_o", {2'h0, 9'h008, 7'h08}, cfg_o);
    check("step_units_o", 18'h1, step_units_o);
    rd(ADDR_CTRL, rdata);
    check("ctrl", 18'h00, rdata);
    rd(ADDR_FB_LO, rdata);
    check("fb_lo", 18'h08, rdata);
    rd(ADDR_IN_DIV, rdata);
    check("in_div", 18'h08, rdata);
    $display("test reset done");

    // every multiplier code, with the feedback msb toggling alongside
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(ADDR_CTRL, {1'b1, m, 4'h0, m[0]});
      check("step_units_o", {15'h0, 1'b0, m} + 18'h1, step_units_o);
      check("mult", {16'h0, m}, cfg_o.mult);
      check("fb_div", {9'h0, m[0], 8'h08}, cfg_o.fb_div);
      rd(ADDR_CTRL, rdata);
      check("ctrl", {10'h0, 1'b0, m, 4'h0, m[0]}, rdata);
    end
    $display("test multiplier done");

    // divider extremes, reserved bit, unmapped address, cut frame
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_FB_LO, 8'hff);
    wr(ADDR_IN_DIV, 8'hff);
    check("fb_div", 18'h1ff, cfg_o.fb_div);
    check("in_div", 18'h7f, cfg_o.in_div);
    rd(ADDR_FB_LO, rdata);
    check("fb_lo", 18'hff, rdata);
    rd(ADDR_IN_DIV, rdata);
    check("in_div", 18'h7f, rdata);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_FB_LO, 8'h00);
    wr(ADDR_IN_DIV, 8'h01);
    check("cfg_o", {2'h0, 9'h000, 7'h01}, cfg_o);
    wr(7'h20, 8'h5a);
    check("cfg_o", {2'h0, 9'h000, 7'h01}, cfg_o);
    rd(7'h20, rdata);
    check("unmapped", 18'h00, rdata);
    cut_wr(ADDR_IN_DIV, 8'h55);
    check("in_div", 18'h01, cfg_o.in_div);
    $display("test dividers done");

    // legal loop for a 983.04 MHz input: compare 122.88 MHz, x8 back
    wr(ADDR_FB_LO, 8'h08);
    wr(ADDR_IN_DIV, 8'h08);
    check("cfg_o", {2'h0, 9'h008, 7'h08}, cfg_o);

    // calibration runs for a middle, a top and a bottom target
    for (int k = 0; k < 3; k++) begin
      target = targets[k];
      wr(ADDR_CAL, 8'h80);
      check("cal_busy_o", 18'h1, cal_busy_o);
      rd(ADDR_CAL, rdata);
      check("cal_rd", 18'h80, rdata);
      n = 0;
      while (cal_busy_o !== 1'b0 && n < 1000) begin
        tick(1);
        n = n + 1;
      end
      check("cal_busy_o", 18'h0, cal_busy_o);
      check("cal_trial_o", {3'h0, target}, cal_trial_o);
      rd(ADDR_RES_HI, rdata);
      check("res_hi", {11'h0, target[14:8]}, rdata);
      rd(ADDR_RES_LO, rdata);
      check("res_lo", {10'h0, target[7:0]}, rdata);
      rd(ADDR_CAL, rdata);
      check("cal_rd", 18'h00, rdata);
    end
    $display("test calibration done");

    results();
  end

endmodule : sysref_delay_calibration_config_tb_top
`default_nettype wire
